// >>> hdl/actc_conv_timing.sv
// Conversion timing and result readout sequencer of a 16-bit converter.
// Assumes pins are asynchronous to clk; sampleCode comes from the core on clk.
//
// Contract
// - A conversion ends within 360 ns (fast) or 485 ns (normal).
// - Busy rises promptly after the falling edge of the start input.
// - Outside master read after convert, busy lasts at most 360/485 ns.
// - Wideband fast mode uses exactly the fast-mode timing.
// - On reset release busy rises about 10 ns later for about 500 ns.
// - Parallel data is valid within the conversion time, before busy falls.
// - Read during convert raises the frame 15/135 ns after the start.
// - The divider code sets a minimum shift period of 8, 16, 32 or 64 ns; read during convert ignores it and shifts at 50 ns.
// - Read after convert keeps busy within the per-divider table limit.
// - Read after convert raises the frame 375/500 ns after the start.
// - Read after convert drops busy shortly after the frame falls; with divider codes 0 and 1 the code cuts busy at the table limit first.
// - Device select high releases frame, shift clock and serial data.
// - Both mode pins high or fast alone select fast, both low normal.
`timescale 1ns/10ps
module actc_conv_timing (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        conversion_start_n,
  input  wire logic        fastSelect,
  input  wire logic        normalSelect,
  input  wire logic        deviceSelect_n,
  input  wire logic        deviceReset,
  input  wire logic        extShiftClock,
  input  wire logic        serial_chain_in,
  input  wire logic [1:0]  shift_clock_divider,
  input  wire logic [1:0]  readMode,
  input  wire logic [15:0] sampleCode,
  output logic             busy,
  output logic [15:0]      parallelData,
  output logic             frameMarker,
  output logic             frameMarkerOe,
  output logic             shiftClock,
  output logic             shiftClockOe,
  output logic             serial_result_out,
  output logic             serialResultOe
);
  logic [actc_pkg::PIN_W-1:0] pinRaw;
  logic [actc_pkg::PIN_W-1:0] syncA;
  logic [actc_pkg::PIN_W-1:0] syncB;

  assign pinRaw = {readMode, shift_clock_divider, serial_chain_in,
                   extShiftClock, deviceReset, deviceSelect_n,
                   normalSelect, fastSelect, conversion_start_n};

  // Two flops per pin; only syncB is read by logic
  for (genvar i = 0; i < actc_pkg::PIN_W; i++)
  begin : g_sync
    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        syncA[i] <= actc_pkg::PIN_RESET[i];
        syncB[i] <= actc_pkg::PIN_RESET[i];
      end
      else
      begin
        syncA[i] <= pinRaw[i];
        syncB[i] <= syncA[i];
      end
    end
  end

  logic       cnvS;
  logic       csS;
  logic       rstS;
  logic       eclkS;
  logic [1:0] divS;
  logic [1:0] modeS;
  assign cnvS  = syncB[actc_pkg::PIN_CNV];
  assign csS   = syncB[actc_pkg::PIN_CS];
  assign rstS  = syncB[actc_pkg::PIN_RST];
  assign eclkS = syncB[actc_pkg::PIN_ECLK];
  assign divS  = syncB[actc_pkg::PIN_DIV0+1:actc_pkg::PIN_DIV0];
  assign modeS = syncB[actc_pkg::PIN_RM0+1:actc_pkg::PIN_RM0];

  // Control group
  actc_pkg::actc_state_t  state;
  actc_pkg::actc_state_t  next_state;
  actc_pkg::actc_rdmode_t modeL;
  actc_pkg::actc_rdmode_t next_modeL;
  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic [6:0] busyLen;
  logic [6:0] next_busyLen;
  logic [1:0] divL;
  logic [1:0] next_divL;
  logic       fastL;
  logic       next_fastL;
  logic       next_busy;
  logic       cnvPrev;
  logic       eclkPrev;
  logic       startEdge;
  logic       startTake;
  logic       goPulse;
  logic       push;
  logic [6:0] convEnd;
  logic [6:0] durSync;
  logic [6:0] aftSync;
  logic [6:0] busyLimit;

  // Readout group
  logic [15:0] shiftWord;
  logic [15:0] next_shiftWord;
  logic [15:0] next_parallelData;
  logic [4:0]  bitCnt;
  logic [4:0]  next_bitCnt;
  logic [1:0]  halfCnt;
  logic [1:0]  next_halfCnt;
  logic [1:0]  halfSel;
  logic        active;
  logic        next_active;
  logic        frameDone;
  logic        next_frameDone;
  logic        dataFresh;
  logic        next_dataFresh;
  logic        next_frameMarker;
  logic        next_shiftClock;
  logic        next_serialOut;
  logic        bufInReady;
  logic        bufOutValid;
  logic        bufOutReady;
  logic [15:0] bufOutWord;
  logic        popTake;

  actc_pair_buffer u_buf (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (push),
    .inReady  (bufInReady),
    .inWord   (sampleCode),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outWord  (bufOutWord)
  );

  always_comb
  begin
    startEdge  = cnvPrev && !cnvS;
    startTake  = 1'b0;
    goPulse    = 1'b0;
    push       = 1'b0;
    next_state = state;
    next_busy  = busy;
    next_fastL = fastL;
    next_modeL = modeL;
    next_divL  = divL;
    next_cnt   = (cnt == 7'h7F) ? cnt : cnt + 7'h01;
    convEnd    = 7'((fastL ? actc_pkg::CONV_FAST_CYC
                      : actc_pkg::CONV_NORM_CYC) - actc_pkg::CONV_PUSH_LEAD);
    durSync    = 7'(fastL ? actc_pkg::SYNC_DUR_FAST_CYC
                          : actc_pkg::SYNC_DUR_NORM_CYC);
    aftSync    = 7'(fastL ? actc_pkg::SYNC_AFT_FAST_CYC
                          : actc_pkg::SYNC_AFT_NORM_CYC);
    busyLimit  = 7'(fastL ? actc_pkg::BUSY_AFT_FAST_CYC[divL]
                          : actc_pkg::BUSY_AFT_NORM_CYC[divL]);
    next_busyLen = busy ? ((busyLen == 7'h7F) ? busyLen : busyLen + 7'h01)
                        : 7'h00;
    if ((state == actc_pkg::ST_CONV || state == actc_pkg::ST_SERIAL) &&
        ((modeL == actc_pkg::RD_MDUR && cnt == durSync - 7'h01) ||
         (modeL == actc_pkg::RD_MAFT && cnt == aftSync - 7'h01)))
      goPulse = 1'b1;
    case (state)
      actc_pkg::ST_IDLE:
      begin
        next_cnt = 7'h00;
        if (startEdge)
        begin
          startTake  = 1'b1;
          next_state = actc_pkg::ST_CONV;
          next_busy  = 1'b1;
          // Wideband and plain fast share one timing set
          next_fastL = syncB[actc_pkg::PIN_FAST];
          next_modeL = actc_pkg::actc_rdmode_t'(modeS);
          next_divL  = divS;
        end
      end
      actc_pkg::ST_RSTDLY:
      begin
        next_cnt  = 7'h00;
        next_busy = 1'b0;
        if (!rstS)
        begin
          next_state = actc_pkg::ST_RSTBUSY;
          next_busy  = 1'b1;
        end
      end
      actc_pkg::ST_RSTBUSY:
      begin
        if (cnt == 7'(actc_pkg::RST_BUSY_CYC - actc_pkg::RST_DLY_CYC))
        begin
          next_state = actc_pkg::ST_IDLE;
          next_busy  = 1'b0;
        end
      end
      actc_pkg::ST_CONV:
      begin
        // A full buffer holds the conversion here rather than drop a word
        if (cnt >= convEnd && bufInReady)
        begin
          push = 1'b1;
          case (modeL)
            actc_pkg::RD_PAR:  next_state = actc_pkg::ST_LOAD;
            actc_pkg::RD_MAFT: next_state = actc_pkg::ST_SERIAL;
            default:
            begin
              next_state = actc_pkg::ST_IDLE;
              next_busy  = 1'b0;
            end
          endcase
        end
      end
      actc_pkg::ST_LOAD:
      begin
        if (dataFresh)
        begin
          next_state = actc_pkg::ST_IDLE;
          next_busy  = 1'b0;
        end
      end
      actc_pkg::ST_SERIAL:
      begin
        // Busy is cut at the table limit even if the frame still runs
        if (frameDone || csS || cnt >= busyLimit - 7'h01)
        begin
          next_state = actc_pkg::ST_IDLE;
          next_busy  = 1'b0;
        end
      end
      default:
      begin
        next_state = actc_pkg::ST_IDLE;
        next_busy  = 1'b0;
      end
    endcase
    if (rstS)
    begin
      next_state = actc_pkg::ST_RSTDLY;
      next_busy  = 1'b0;
      startTake  = 1'b0;
      push       = 1'b0;
      goPulse    = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state    <= actc_pkg::ST_IDLE;
      busy     <= 1'b0;
      fastL    <= 1'b0;
      modeL    <= actc_pkg::RD_PAR;
      divL     <= 2'h0;
      cnt      <= 7'h00;
      busyLen  <= 7'h00;
      cnvPrev  <= 1'b1;
      eclkPrev <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      busy     <= next_busy;
      fastL    <= next_fastL;
      modeL    <= next_modeL;
      divL     <= next_divL;
      cnt      <= next_cnt;
      busyLen  <= next_busyLen;
      cnvPrev  <= cnvS;
      eclkPrev <= eclkS;
    end
  end

  always_comb
  begin
    halfSel = (modeL == actc_pkg::RD_MAFT)
              ? 2'(actc_pkg::DIV_HALF_CYC[divL])
              : 2'(actc_pkg::DIV_HALF_CYC[0]);
    bufOutReady = !active && !(modeL == actc_pkg::RD_SLAVE &&
                  bitCnt != 5'h00 && bitCnt != 5'h10);
    popTake           = bufOutValid && bufOutReady;
    next_shiftWord    = shiftWord;
    next_parallelData = parallelData;
    next_bitCnt       = bitCnt;
    next_halfCnt      = halfCnt;
    next_active       = active;
    next_frameDone    = 1'b0;
    next_dataFresh    = startTake ? 1'b0 : dataFresh;
    next_frameMarker  = frameMarker;
    next_shiftClock   = shiftClock;
    next_serialOut    = serial_result_out;
    if (popTake)
    begin
      if (modeL == actc_pkg::RD_PAR)
      begin
        next_parallelData = bufOutWord;
        next_dataFresh    = 1'b1;
      end
      else
      begin
        next_shiftWord = bufOutWord;
        next_bitCnt    = 5'h10;
        next_serialOut = bufOutWord[15];
      end
    end
    if (goPulse && !active && !csS && bitCnt != 5'h00)
    begin
      next_active      = 1'b1;
      next_frameMarker = 1'b1;
      next_halfCnt     = 2'h0;
      next_shiftClock  = 1'b0;
    end
    else if (active)
    begin
      if (halfCnt == halfSel - 2'h1)
      begin
        next_halfCnt    = 2'h0;
        next_shiftClock = !shiftClock;
        if (shiftClock)
        begin
          next_shiftWord = {shiftWord[14:0], syncB[actc_pkg::PIN_CHAIN]};
          next_serialOut = shiftWord[14];
          next_bitCnt    = bitCnt - 5'h01;
          if (bitCnt == 5'h01)
          begin
            next_active      = 1'b0;
            next_frameMarker = 1'b0;
            next_shiftClock  = 1'b0;
            next_frameDone   = 1'b1;
          end
        end
      end
      else
        next_halfCnt = halfCnt + 2'h1;
    end
    // Host clock only steps the word; its period is the host's concern
    if (modeL == actc_pkg::RD_SLAVE && eclkS && !eclkPrev &&
        bitCnt != 5'h00)
    begin
      next_shiftWord = {shiftWord[14:0], syncB[actc_pkg::PIN_CHAIN]};
      next_serialOut = shiftWord[14];
      next_bitCnt    = bitCnt - 5'h01;
    end
    if (rstS)
    begin
      next_active      = 1'b0;
      next_frameMarker = 1'b0;
      next_shiftClock  = 1'b0;
      next_bitCnt      = 5'h00;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      shiftWord         <= 16'h0000;
      parallelData      <= 16'h0000;
      bitCnt            <= 5'h00;
      halfCnt           <= 2'h0;
      active            <= 1'b0;
      frameDone         <= 1'b0;
      dataFresh         <= 1'b0;
      frameMarker       <= 1'b0;
      shiftClock        <= 1'b0;
      serial_result_out <= 1'b0;
      frameMarkerOe     <= 1'b0;
      shiftClockOe      <= 1'b0;
      serialResultOe    <= 1'b0;
    end
    else
    begin
      shiftWord         <= next_shiftWord;
      parallelData      <= next_parallelData;
      bitCnt            <= next_bitCnt;
      halfCnt           <= next_halfCnt;
      active            <= next_active;
      frameDone         <= next_frameDone;
      dataFresh         <= next_dataFresh;
      frameMarker       <= next_frameMarker;
      shiftClock        <= next_shiftClock;
      serial_result_out <= next_serialOut;
      frameMarkerOe     <= !csS && modeL != actc_pkg::RD_PAR;
      shiftClockOe      <= !csS && (modeL == actc_pkg::RD_MDUR ||
                                    modeL == actc_pkg::RD_MAFT);
      serialResultOe    <= !csS && modeL != actc_pkg::RD_PAR;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_busyRise;
    (state == actc_pkg::ST_IDLE && startEdge && !rstS) |=> busy;
  endproperty
  a_busyRise: assert property (p_busyRise)
    else $error("busy did not rise after start");

  property p_busyPar;
    (busy && modeL == actc_pkg::RD_PAR && state != actc_pkg::ST_RSTBUSY)
      |-> busyLen < 7'(fastL ? actc_pkg::CONV_FAST_CYC
                             : actc_pkg::CONV_NORM_CYC);
  endproperty
  a_busyPar: assert property (p_busyPar)
    else $error("busy exceeded conversion limit");

  property p_rstBusy;
    (state == actc_pkg::ST_RSTDLY && !rstS) |=> busy [*8];
  endproperty
  a_rstBusy: assert property (p_rstBusy)
    else $error("busy not held after reset release");

  property p_parData;
    ($fell(busy) && modeL == actc_pkg::RD_PAR && $past(state) ==
      actc_pkg::ST_LOAD) |-> $past(dataFresh);
  endproperty
  a_parData: assert property (p_parData)
    else $error("parallel data not ready before busy fell");

  property p_syncDur;
    ($rose(frameMarker) && modeL == actc_pkg::RD_MDUR) |-> cnt == durSync;
  endproperty
  a_syncDur: assert property (p_syncDur)
    else $error("frame marker late in read during convert");

  property p_syncAft;
    ($rose(frameMarker) && modeL == actc_pkg::RD_MAFT) |-> cnt == aftSync;
  endproperty
  a_syncAft: assert property (p_syncAft)
    else $error("frame marker late in read after convert");

  property p_div3;
    ($rose(shiftClock) && modeL == actc_pkg::RD_MAFT && divL == 2'h3)
      |-> shiftClock [*2] ##1 !shiftClock;
  endproperty
  a_div3: assert property (p_div3)
    else $error("shift clock half period wrong for slowest divider");

  property p_busyAft;
    (busy && modeL == actc_pkg::RD_MAFT && state != actc_pkg::ST_RSTBUSY)
      |-> busyLen <= busyLimit;
  endproperty
  a_busyAft: assert property (p_busyAft)
    else $error("busy exceeded read after convert limit");

  property p_frameEnd;
    ($fell(frameMarker) && state == actc_pkg::ST_SERIAL && !rstS)
      |=> $fell(busy);
  endproperty
  a_frameEnd: assert property (p_frameEnd)
    else $error("busy did not fall after frame end");

  property p_release;
    csS |=> !frameMarkerOe && !shiftClockOe && !serialResultOe;
  endproperty
  a_release: assert property (p_release)
    else $error("serial pins still driven while deselected");

  property p_modeDecode;
    (state == actc_pkg::ST_IDLE && startEdge && !rstS)
      |=> fastL == $past(syncB[actc_pkg::PIN_FAST]);
  endproperty
  a_modeDecode: assert property (p_modeDecode)
    else $error("speed mode not latched at start");
endmodule

// >>> hdl/actc_pkg.sv
// Constants and types shared by the conversion timing controller.
// Assumes a single 40 MHz clock; every time becomes cycles of that clock.
package actc_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int WORD_W        = 16;
  localparam int CNT_W         = 7;

  // Conversion and busy limits, fast and normal mode
  localparam int CONV_FAST_NS  = 360;
  localparam int CONV_NORM_NS  = 485;
  localparam int CONV_FAST_CYC = CONV_FAST_NS / CLK_PERIOD_NS;
  localparam int CONV_NORM_CYC = CONV_NORM_NS / CLK_PERIOD_NS;
  // Result is pushed this many cycles before the conversion limit
  localparam int CONV_PUSH_LEAD = 3;

  // Busy pulse after the reset input is released
  localparam int RST_DLY_NS    = 10;
  localparam int RST_DLY_CYC   = (RST_DLY_NS / CLK_PERIOD_NS < 1) ? 1
                                 : RST_DLY_NS / CLK_PERIOD_NS;
  localparam int RST_BUSY_NS   = 500;
  localparam int RST_BUSY_CYC  = RST_BUSY_NS / CLK_PERIOD_NS;

  // Frame marker delays from conversion start
  localparam int SYNC_DUR_FAST_NS  = 15;
  localparam int SYNC_DUR_NORM_NS  = 135;
  localparam int SYNC_DUR_FAST_CYC = (SYNC_DUR_FAST_NS / CLK_PERIOD_NS < 1)
                                     ? 1 : SYNC_DUR_FAST_NS / CLK_PERIOD_NS;
  localparam int SYNC_DUR_NORM_CYC = SYNC_DUR_NORM_NS / CLK_PERIOD_NS;
  localparam int SYNC_AFT_FAST_NS  = 375;
  localparam int SYNC_AFT_NORM_NS  = 500;
  localparam int SYNC_AFT_FAST_CYC = SYNC_AFT_FAST_NS / CLK_PERIOD_NS;
  localparam int SYNC_AFT_NORM_CYC = SYNC_AFT_NORM_NS / CLK_PERIOD_NS;

  // Minimum shift clock period per divider code, and half period in cycles
  localparam int DIV_PERIOD_NS [4] = '{8, 16, 32, 64};
  localparam int DIV_HALF_CYC  [4] = '{
    (DIV_PERIOD_NS[0] + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS),
    (DIV_PERIOD_NS[1] + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS),
    (DIV_PERIOD_NS[2] + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS),
    (DIV_PERIOD_NS[3] + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS)};

  // Longest busy in master read after convert, per divider code
  localparam int BUSY_AFT_FAST_NS [4] = '{640, 920, 1470, 2570};
  localparam int BUSY_AFT_NORM_NS [4] = '{760, 1040, 1590, 2690};
  localparam int BUSY_AFT_FAST_CYC [4] = '{
    BUSY_AFT_FAST_NS[0] / CLK_PERIOD_NS, BUSY_AFT_FAST_NS[1] / CLK_PERIOD_NS,
    BUSY_AFT_FAST_NS[2] / CLK_PERIOD_NS, BUSY_AFT_FAST_NS[3] / CLK_PERIOD_NS};
  localparam int BUSY_AFT_NORM_CYC [4] = '{
    BUSY_AFT_NORM_NS[0] / CLK_PERIOD_NS, BUSY_AFT_NORM_NS[1] / CLK_PERIOD_NS,
    BUSY_AFT_NORM_NS[2] / CLK_PERIOD_NS, BUSY_AFT_NORM_NS[3] / CLK_PERIOD_NS};

  // Synchronised pin vector layout and its value after reset
  localparam int PIN_W     = 11;
  localparam int PIN_CNV   = 0;
  localparam int PIN_FAST  = 1;
  localparam int PIN_NORM  = 2;
  localparam int PIN_CS    = 3;
  localparam int PIN_RST   = 4;
  localparam int PIN_ECLK  = 5;
  localparam int PIN_CHAIN = 6;
  localparam int PIN_DIV0  = 7;
  localparam int PIN_RM0   = 9;
  localparam logic [PIN_W-1:0] PIN_RESET = 11'h009;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RSTDLY  = 3'b001,
    ST_RSTBUSY = 3'b010,
    ST_CONV    = 3'b011,
    ST_LOAD    = 3'b100,
    ST_SERIAL  = 3'b101
  } actc_state_t;

  typedef enum logic [1:0] {
    RD_PAR   = 2'b00,
    RD_MDUR  = 2'b01,
    RD_MAFT  = 2'b10,
    RD_SLAVE = 2'b11
  } actc_rdmode_t;

endpackage

// >>> hdl/actc_pair_buffer.sv
// Two-entry result buffer with valid/ready on both sides.
// Assumes both sides sit on clk; a stalled reader backs up into inReady.
`timescale 1ns/10ps
module actc_pair_buffer (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        inValid,
  output logic             inReady,
  input  wire logic [15:0] inWord,
  output logic             outValid,
  input  wire logic        outReady,
  output logic [15:0]      outWord
);
  logic [15:0] mem [2];
  logic [15:0] next_mem [2];
  logic        wrPtr;
  logic        next_wrPtr;
  logic        rdPtr;
  logic        next_rdPtr;
  logic [1:0]  count;
  logic [1:0]  next_count;
  logic        doWrite;
  logic        doRead;

  assign inReady  = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outWord  = mem[rdPtr];

  always_comb
  begin
    doWrite    = inValid && inReady;
    doRead     = outValid && outReady;
    next_mem   = mem;
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (doWrite)
    begin
      next_mem[wrPtr] = inWord;
      next_wrPtr      = ~wrPtr;
    end
    if (doRead)
      next_rdPtr = ~rdPtr;
    if (doWrite && !doRead)
      next_count = count + 2'h1;
    else if (doRead && !doWrite)
      next_count = count - 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem[0] <= 16'h0000;
      mem[1] <= 16'h0000;
      wrPtr  <= 1'b0;
      rdPtr  <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      mem   <= next_mem;
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end
endmodule

// >>> tb/actc_host_model.sv
// Host model: paces conversion starts and clocks slave readout.
// Assumes the bench pulses go for one cycle and holds sh to read.
`timescale 1ns/10ps
module actc_host_model (
  input  wire logic   clk,
  input  wire logic   go,
  input  wire logic   sh,
  input  wire logic   sdo,
  output logic        cnvN,
  output logic        sck,
  output logic        rdy,
  output logic [15:0] rx,
  output int          rxCnt
);
  int gap = 0;
  int ph = 0;
  initial
  begin
    cnvN = 1'b1;
    sck = 1'b0;
    rx = 16'h0000;
    rxCnt = 0;
  end
  assign rdy = gap == 0;
  always @(posedge clk)
  begin
    cnvN <= !(go && rdy);
    // 30 cycles cover both start spacing and acquisition in either mode
    gap <= (go && rdy) ? 30 : (gap > 0 ? gap - 1 : 0);
    ph <= sh ? (ph + 1) % 8 : 0;
    // 200 ns period, still low between reads
    sck <= sh && ph >= 3 && ph < 7;
    if (!sh)
      rxCnt <= 0;
    else if (ph == 2)
    begin
      rx <= {rx[14:0], sdo};
      rxCnt <= rxCnt + 1;
    end
  end
endmodule

// >>> tb/adc_conversion_timing_ctrl_test.sv
// Self-checking bench of the conversion timing controller.
// Assumes the host model on the start and slave clock pins.
`timescale 1ns/10ps
module adc_conversion_timing_ctrl_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        fastSel = 1'b1;
  logic        normSel = 1'b0;
  logic        select_n = 1'b0;
  logic        devRst = 1'b0;
  logic        chainIn = 1'b0;
  logic        go = 1'b0;
  logic        sh = 1'b0;
  logic        sckPrev = 1'b0;
  logic        cnvN, eClk, rdy, busy, frame, frameOe, sck, sckOe, sOut, sOe;
  logic [1:0]  div = 2'b00;
  logic [1:0]  rm = 2'b00;
  logic [15:0] code = 16'h0000;
  logic [15:0] capWord = 16'h0000;
  logic [15:0] pData, rx;
  logic [31:0] rng = 32'h0001_8314;
  int          rxCnt, capCnt = 0, sckCyc = 0, sckGap = 0;
  int          miscompares = 0;
  int          n_compared = 0;

  actc_conv_timing actc_conv_timing_inst (
    .clk(clk), .rst_n(rst_n), .conversion_start_n(cnvN),
    .fastSelect(fastSel), .normalSelect(normSel),
    .deviceSelect_n(select_n), .deviceReset(devRst),
    .extShiftClock(eClk), .serial_chain_in(chainIn),
    .shift_clock_divider(div), .readMode(rm), .sampleCode(code),
    .busy(busy), .parallelData(pData), .frameMarker(frame),
    .frameMarkerOe(frameOe), .shiftClock(sck), .shiftClockOe(sckOe),
    .serial_result_out(sOut), .serialResultOe(sOe));
  actc_host_model actc_host_model_inst (
    .clk(clk), .go(go), .sh(sh), .sdo(sOut), .cnvN(cnvN), .sck(eClk),
    .rdy(rdy), .rx(rx), .rxCnt(rxCnt));

  initial forever #12.5 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Frame capture on shift clock rises, and the last rise spacing
  always @(posedge clk)
  begin
    rng <= xs(rng);
    chainIn <= rng[0];
    sckPrev <= sck;
    sckCyc <= (sck && !sckPrev) ? 1 : sckCyc + 1;
    if (go)
      capCnt <= 0;
    else if (frame && sck && !sckPrev)
    begin
      capWord <= {capWord[14:0], sOut};
      capCnt <= capCnt + 1;
      if (capCnt > 0)
        sckGap <= sckCyc;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic measure(output int len, output int fDly);
    int i;
    len = 0;
    fDly = -1;
    for (i = 0; i < 12 && busy !== 1'b1; i++) @(posedge clk);
    while (busy === 1'b1 && len < 300)
    begin
      if (frame === 1'b1 && fDly < 0) fDly = len;
      len++;
      @(posedge clk);
    end
  endtask

  task automatic run_conv(output int len, output int fDly);
    int i;
    for (i = 0; i < 40 && rdy !== 1'b1; i++) @(posedge clk);
    code <= rng[15:0];
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    measure(len, fDly);
    for (i = 0; i < 300 && frame === 1'b1; i++) @(posedge clk);
  endtask

  initial
  begin
    int len, fDly, lim, c, d, mi, r, k;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(busy, 1'b0);
    check(pData, 16'h0000);
    // Modes: wideband fast, fast, normal; every read mode twice
    for (mi = 0; mi < 3; mi++)
      for (r = 0; r < 4; r++)
        for (k = 0; k < 2; k++)
        begin
          fastSel <= mi < 2;
          normSel <= mi == 0;
          rm <= r[1:0];
          div <= rng[3:2];
          @(posedge clk);
          c = mi < 2 ? actc_pkg::CONV_FAST_CYC : actc_pkg::CONV_NORM_CYC;
          run_conv(len, fDly);
          if (r == 0) check(pData, code);
          // Read during convert and slave modes drop busy at the push, parallel waits for the load
          if (r != 2) check(len, r == 0 ? c : c - actc_pkg::CONV_PUSH_LEAD + 1);
          d = mi < 2 ? actc_pkg::SYNC_DUR_FAST_CYC
                     : actc_pkg::SYNC_DUR_NORM_CYC;
          if (r == 1 && k == 1) check(fDly >= d - 1 && fDly <= d + 1, 1);
          if (r == 2)
          begin
            lim = mi < 2 ? actc_pkg::BUSY_AFT_FAST_CYC[div]
                         : actc_pkg::BUSY_AFT_NORM_CYC[div];
            d = mi < 2 ? actc_pkg::SYNC_AFT_FAST_CYC
                       : actc_pkg::SYNC_AFT_NORM_CYC;
            check(len <= lim && len > 0, 1);
            check(fDly >= d - 1 && fDly <= d + 1, 1);
            check(capCnt, 16);
            check(capWord, code);
            check(sckGap * 25 >= actc_pkg::DIV_PERIOD_NS[div], 1);
          end
        end
    run_conv(len, fDly);
    sh <= 1'b1;
    for (k = 0; k < 300 && rxCnt < 16; k++) @(posedge clk);
    check(rx, code);
    sh <= 1'b0;
    select_n <= 1'b1;
    repeat (6) @(posedge clk);
    check({frameOe, sckOe, sOe}, 3'b000);
    select_n <= 1'b0;
    repeat (6) @(posedge clk);
    check(sOe, 1'b1);
    devRst <= 1'b1;
    repeat (4) @(posedge clk);
    check(busy, 1'b0);
    devRst <= 1'b0;
    measure(len, fDly);
    check(len, actc_pkg::RST_BUSY_CYC);
    tally_and_finish();
  end

  initial
  begin
    #500000;
    miscompares++;
    tally_and_finish();
  end
endmodule
